// File: logic/csw_regs.sv
// apb bank of read-only channel and unit status words
//
// Operation
// - status bit 0: zero run, one stop
// - status bit 1: zero auto, one manual
// - status bit 2: autotune executing
// - status bit 3: local or remote setpoint
// - status bit 4: self-tuning executing
// - status bit 5: setpoint ramp in progress
// - status bit 8: measurement input error
// - status bit 9: remote setpoint input error
// - status words at 0101, 0201, 0301, 0401
// - alarm words at 0102, 0202, 0302, 0402
// - alarm bits 0-2 follow configured alarms
// - alarm bit 4: heater overcurrent detected
// - alarm bits 5-7: burnout, short, overcurrent
// - alarm bit 12: setpoint outside limiter
// - alarm bit 13: setpoint limits reversed
// - alarm bit 14: output limits reversed
// - alarm bit 15: scaling limits reversed
// - unit bit 20: backup or ram-only write
// - unit bit 21: ram differs from nonvolatile
// - unit bit 25 always reads one
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module csw_regs
    import csw_pkg::*;
(
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [15:0]             paddr,
    input  wire logic [31:0]             pwdata,
    output var  logic [31:0]             prdata,
    output logic                         pready,
    output var  logic                    pslverr,
    input  wire csw_state_in_t [CH_COUNT-1:0] chan_state,
    input  wire csw_alarm_in_t [CH_COUNT-1:0] chan_alarm,
    input  wire csw_limits_t   [CH_COUNT-1:0] chan_limits,
    input  wire logic                    ram_only_write_mode,
    input  wire logic                    nvm_differs
);

    // assertions share one clock and the bus reset
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // registered status words, one pair per channel
    logic [15:0] state_q      [CH_COUNT];
    logic [15:0] alarm_q      [CH_COUNT];
    logic [15:0] next_state_q [CH_COUNT];
    logic [15:0] next_alarm_q [CH_COUNT];

    // registered unit word
    logic [31:0] unit_q;
    logic [31:0] next_unit_q;

    // read path
    logic [31:0] next_prdata;
    logic        next_pslverr;
    logic        setup_rd;

    // write data is never stored: every word is read-only
    // folded into one bit so the unused input is plainly deliberate
    logic        unused_wdata;
    assign unused_wdata = ^pwdata;

    // per-channel word builders
    for (genvar i = 0; i < CH_COUNT; i++) begin : g_ch

        // assemble both words from the loop's live state
        always_comb begin
            next_state_q[i]           = STATE_RESET;
            next_state_q[i][ST_STOP]  = chan_state[i].stopped;
            next_state_q[i][ST_MAN]   = chan_state[i].manual;
            next_state_q[i][ST_AT]    = chan_state[i].autotune_running;
            next_state_q[i][ST_SRC]   = chan_state[i].setpoint_source;
            next_state_q[i][ST_SELF]  = chan_state[i].self_tuning;
            next_state_q[i][ST_RAMP]  = chan_state[i].ramp_active;
            next_state_q[i][ST_INERR] = chan_state[i].input_error;
            next_state_q[i][ST_RSERR] = chan_state[i].remote_setpoint_error;

            next_alarm_q[i] = ALARM_RESET;
            // configured alarms one to three
            next_alarm_q[i][AL_FIRST+:3] = chan_alarm[i].alarm_active;
            next_alarm_q[i][AL_HOC] = chan_alarm[i].heater_overcurrent;
            next_alarm_q[i][AL_HB]  = chan_alarm[i].heater_burnout_alarm;
            next_alarm_q[i][AL_HS]  = chan_alarm[i].heater_short_alarm;
            next_alarm_q[i][AL_OC]  = chan_alarm[i].overcurrent_alarm;
            // limit checks are signed: negative setpoints are legal
            next_alarm_q[i][AL_SPOUT] =
                ($signed(chan_limits[i].setpoint) > $signed(chan_limits[i].sp_upper)) ||
                ($signed(chan_limits[i].setpoint) < $signed(chan_limits[i].sp_lower));
            next_alarm_q[i][AL_SPREV] =
                $signed(chan_limits[i].sp_upper) < $signed(chan_limits[i].sp_lower);
            next_alarm_q[i][AL_MVREV] =
                $signed(chan_limits[i].mv_upper) < $signed(chan_limits[i].mv_lower);
            next_alarm_q[i][AL_SCREV] =
                $signed(chan_limits[i].scale_upper) < $signed(chan_limits[i].scale_lower);
        end

        // register so a read never sees a half-updated word
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                state_q[i] <= STATE_RESET;
                alarm_q[i] <= ALARM_RESET;
            end else begin
                state_q[i] <= next_state_q[i];
                alarm_q[i] <= next_alarm_q[i];
            end
        end

        // stop bit follows the run state one cycle later
        a_run_stop_bit: assert property (
            state_q[i][ST_STOP] == $past(chan_state[i].stopped))
            else $error("stop bit does not follow run state");

        // manual bit
        a_manual_mode_bit: assert property (
            $rose(chan_state[i].manual) |=> state_q[i][ST_MAN])
            else $error("manual bit missed");

        // autotune bit
        a_autotune_bit: assert property (
            $fell(chan_state[i].autotune_running) |=> !state_q[i][ST_AT])
            else $error("autotune bit stuck after cancel");

        // setpoint source bit
        a_setpoint_src_bit: assert property (
            state_q[i][ST_SRC] == $past(chan_state[i].setpoint_source))
            else $error("setpoint source bit wrong");

        // self-tuning bit
        a_self_tune_bit: assert property (
            chan_state[i].self_tuning [*2] |-> state_q[i][ST_SELF])
            else $error("self-tuning bit low while running");

        // ramp bit
        a_ramp_bit: assert property (
            !chan_state[i].ramp_active [*2] |-> !state_q[i][ST_RAMP])
            else $error("ramp bit high with no ramp");

        // input error bit
        a_input_err_bit: assert property (
            state_q[i][ST_INERR] == $past(chan_state[i].input_error))
            else $error("input error bit wrong");

        // remote setpoint error bit
        a_remote_err_bit: assert property (
            $rose(chan_state[i].remote_setpoint_error) |=> state_q[i][ST_RSERR])
            else $error("remote setpoint error missed");

        // configured alarms
        a_alarm_trio: assert property (
            alarm_q[i][2:0] == $past(chan_alarm[i].alarm_active))
            else $error("alarm one to three mismatch");

        // heater overcurrent
        a_heater_oc_bit: assert property (
            alarm_q[i][AL_HOC] == $past(chan_alarm[i].heater_overcurrent))
            else $error("heater overcurrent bit wrong");

        // burnout, short, overcurrent alarms
        a_heater_alarms: assert property (
            alarm_q[i][7:5] == $past({chan_alarm[i].overcurrent_alarm,
                chan_alarm[i].heater_short_alarm, chan_alarm[i].heater_burnout_alarm}))
            else $error("heater alarm bits misplaced");

        // setpoint above the upper limit
        a_sp_range_bit: assert property (
            $signed(chan_limits[i].setpoint) > $signed(chan_limits[i].sp_upper)
            |=> alarm_q[i][AL_SPOUT])
            else $error("setpoint out of range not flagged");

        // reversed setpoint limits
        a_sp_reverse_bit: assert property (
            alarm_q[i][AL_SPREV] == $past($signed(chan_limits[i].sp_upper)
                < $signed(chan_limits[i].sp_lower)))
            else $error("setpoint limit reversal wrong");

        // reversed output limits
        a_mv_reverse_bit: assert property (
            alarm_q[i][AL_MVREV] == $past($signed(chan_limits[i].mv_upper)
                < $signed(chan_limits[i].mv_lower)))
            else $error("output limit reversal wrong");

        // reversed scaling limits
        a_scale_reverse_bit: assert property (
            alarm_q[i][AL_SCREV] == $past($signed(chan_limits[i].scale_upper)
                < $signed(chan_limits[i].scale_lower)))
            else $error("scaling reversal wrong");

        // unused bits of both words stay zero
        a_unused_zero: assert property (
            ((state_q[i] & ~STATE_USED) == 16'h0000) && ((alarm_q[i] & ~ALARM_USED) == 16'h0000))
            else $error("unused channel bit set");

        // a read of the status word returns the word
        a_state_read: assert property (
            (setup_rd && paddr == {CH_STATE_IDX[i], 2'b00}) |=>
            (prdata == {16'h0000, $past(state_q[i])}) && !pslverr)
            else $error("status word read wrong");

        // a read of the alarm word returns the word
        a_alarm_read: assert property (
            (setup_rd && paddr == {CH_ALARM_IDX[i], 2'b00}) |=>
            (prdata == {16'h0000, $past(alarm_q[i])}) && !pslverr)
            else $error("alarm word read wrong");

        // the companion checks below catch a bit stuck at the other level, and a_sp_below_bit covers the lower limit
        // manual bit drops when automatic control resumes
        a_manual_clear: assert property (
            $fell(chan_state[i].manual) |=> !state_q[i][ST_MAN])
            else $error("manual bit stuck after return to auto");

        // autotune bit rises when tuning starts
        a_autotune_set: assert property (
            $rose(chan_state[i].autotune_running) |=> state_q[i][ST_AT])
            else $error("autotune bit missed");

        // self-tuning bit clears once tuning stops
        a_self_tune_clr: assert property (
            !chan_state[i].self_tuning [*2] |-> !state_q[i][ST_SELF])
            else $error("self-tuning bit high while stopped");

        // ramp bit stays up for the whole ramp
        a_ramp_set: assert property (
            chan_state[i].ramp_active [*2] |-> state_q[i][ST_RAMP])
            else $error("ramp bit low during ramp");

        // remote setpoint error clears with its cause
        a_remote_err_clr: assert property (
            $fell(chan_state[i].remote_setpoint_error) |=> !state_q[i][ST_RSERR])
            else $error("remote setpoint error stuck");

        // setpoint below the lower limit is out of range too
        a_sp_below_bit: assert property (
            $signed(chan_limits[i].setpoint) < $signed(chan_limits[i].sp_lower)
            |=> alarm_q[i][AL_SPOUT])
            else $error("setpoint below range not flagged");

        // a setpoint inside both limits raises nothing
        a_sp_inside_bit: assert property (
            ($signed(chan_limits[i].setpoint) <= $signed(chan_limits[i].sp_upper)) &&
            ($signed(chan_limits[i].setpoint) >= $signed(chan_limits[i].sp_lower))
            |=> !alarm_q[i][AL_SPOUT])
            else $error("setpoint in range flagged");
    end

    // unit word: mode and memory match, permission fixed high
    // permission is tied high: software has no way to turn it off
    always_comb begin
        next_unit_q           = UNIT_RESET;
        next_unit_q[UN_WMODE] = ram_only_write_mode;
        next_unit_q[UN_NVM]   = nvm_differs;
        next_unit_q[UN_COMM]  = 1'b1;
    end

    // unit word register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unit_q <= UNIT_RESET;
        end else begin
            unit_q <= next_unit_q;
        end
    end

    // write mode bit
    a_write_mode_bit: assert property (
        unit_q[UN_WMODE] == $past(ram_only_write_mode))
        else $error("write mode bit wrong");

    // memory match bit
    a_nvm_match_bit: assert property (
        $rose(nvm_differs) |=> unit_q[UN_NVM])
        else $error("memory mismatch not shown");

    // permission bit never drops, unused unit bits stay zero
    a_comm_perm_bit: assert property (
        unit_q[UN_COMM] && ((unit_q & ~UNIT_USED) == 32'h0000_0000))
        else $error("unit word fixed bits wrong");

    // memory match bit clears once settings are stored
    a_nvm_clear_bit: assert property (
        $fell(nvm_differs) |=> !unit_q[UN_NVM])
        else $error("memory mismatch stuck");

    // a read of the unit word returns the word
    a_unit_read: assert property (
        (setup_rd && paddr == {UNIT_IDX, 2'b00}) |=> (prdata == $past(unit_q)) && !pslverr)
        else $error("unit word read wrong");

    // the read is sampled in the setup cycle, so the access phase
    // never waits; writes complete the same way but store nothing
    assign setup_rd = psel && !penable && !pwrite;

    // address decode and read mux
    always_comb begin
        next_prdata  = prdata;
        next_pslverr = pslverr;
        if (psel && !penable) begin
            // unmapped unless a word matches below
            next_prdata  = 32'h0000_0000;
            next_pslverr = 1'b1;
            if (paddr == {UNIT_IDX, 2'b00}) begin
                next_pslverr = 1'b0;
                if (!pwrite) begin
                    next_prdata = unit_q;
                end
            end
            for (int k = 0; k < CH_COUNT; k++) begin
                // channel operating-state word
                if (paddr == {CH_STATE_IDX[k], 2'b00}) begin
                    next_pslverr = 1'b0;
                    if (!pwrite) begin
                        next_prdata = {16'h0000, state_q[k]};
                    end
                end
                // channel alarm word
                if (paddr == {CH_ALARM_IDX[k], 2'b00}) begin
                    next_pslverr = 1'b0;
                    if (!pwrite) begin
                        next_prdata = {16'h0000, alarm_q[k]};
                    end
                end
            end
        end
    end

    // read data and error flags held until the next setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            prdata  <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    // zero wait states
    assign pready = psel && penable;

    // a write to any word stores nothing and leaves the read data at zero
    a_write_ignored: assert property (
        (psel && !penable && pwrite) |=> (prdata == 32'h0000_0000) ##1 (unit_q[UN_COMM]))
        else $error("write disturbed read data");

    // misaligned address answers with an error
    a_unmapped_err: assert property (
        (psel && !penable && paddr[1:0] != 2'b00) |=> pslverr && pready == penable)
        else $error("misaligned address accepted");

    // read data and error stand until the next setup cycle
    a_read_data_hold: assert property (
        !(psel && !penable) |=> $stable(prdata) && $stable(pslverr))
        else $error("read data changed outside setup");

    // main scenarios
    // each kind of transfer is seen at least once
    c_state_read: cover property (setup_rd && paddr == {CH_STATE_IDX[3], 2'b00} ##1 pready);
    c_alarm_read: cover property (setup_rd && paddr == {CH_ALARM_IDX[0], 2'b00} ##1 pready);
    c_unit_read: cover property (setup_rd && paddr == {UNIT_IDX, 2'b00} ##1 pready);
    c_bad_addr: cover property (psel && penable && pslverr);
    c_write_done: cover property (psel && !penable && pwrite ##1 pready && !pslverr);

endmodule

`default_nettype wire

// File: logic/csw_pkg.sv
// package: map, bit positions, reset values and carrier types of the status words
package csw_pkg;

    // number of control channels
    localparam int CH_COUNT = 4;

    // register indices; byte address is four times the index
    localparam logic [13:0] UNIT_IDX = 14'h0001;
    localparam logic [13:0] CH_STATE_IDX [CH_COUNT] = '{14'h0101, 14'h0201, 14'h0301, 14'h0401};
    localparam logic [13:0] CH_ALARM_IDX [CH_COUNT] = '{14'h0102, 14'h0202, 14'h0302, 14'h0402};

    // channel operating-state word bit positions
    localparam int ST_STOP  = 0;
    localparam int ST_MAN   = 1;
    localparam int ST_AT    = 2;
    localparam int ST_SRC   = 3;
    localparam int ST_SELF  = 4;
    localparam int ST_RAMP  = 5;
    localparam int ST_INERR = 8;
    localparam int ST_RSERR = 9;

    // channel alarm word bit positions
    localparam int AL_FIRST = 0;
    localparam int AL_HOC   = 4;
    localparam int AL_HB    = 5;
    localparam int AL_HS    = 6;
    localparam int AL_OC    = 7;
    localparam int AL_SPOUT = 12;
    localparam int AL_SPREV = 13;
    localparam int AL_MVREV = 14;
    localparam int AL_SCREV = 15;

    // unit word bit positions
    localparam int UN_WMODE = 20;
    localparam int UN_NVM   = 21;
    localparam int UN_COMM  = 25;

    // values after reset; write permission always reads one
    localparam logic [15:0] STATE_RESET = 16'h0000;
    localparam logic [15:0] ALARM_RESET = 16'h0000;
    localparam logic [31:0] UNIT_RESET  = 32'h0200_0000;

    // masks of the bits that carry meaning
    localparam logic [15:0] STATE_USED = 16'h033F;
    localparam logic [15:0] ALARM_USED = 16'hF0F7;
    localparam logic [31:0] UNIT_USED  = 32'h0230_0000;

    // per-channel state reported by the control loop
    typedef struct packed {
        logic stopped;
        logic manual;
        logic autotune_running;
        logic setpoint_source;
        logic self_tuning;
        logic ramp_active;
        logic input_error;
        logic remote_setpoint_error;
    } csw_state_in_t;

    // per-channel alarm conditions
    typedef struct packed {
        logic [2:0] alarm_active;
        logic       heater_overcurrent;
        logic       heater_burnout_alarm;
        logic       heater_short_alarm;
        logic       overcurrent_alarm;
    } csw_alarm_in_t;

    // per-channel configured limits, two's complement
    typedef struct packed {
        logic [15:0] setpoint;
        logic [15:0] sp_upper;
        logic [15:0] sp_lower;
        logic [15:0] mv_upper;
        logic [15:0] mv_lower;
        logic [15:0] scale_upper;
        logic [15:0] scale_lower;
    } csw_limits_t;

endpackage

// File: verification/csw_host_model.sv
// host model: an apb master that issues one transfer at a time
`timescale 1ns/1ps
`default_nettype none

module csw_host_model (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [15:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    // bus idle from time zero
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 16'h0000;
        pwdata  = 32'h0000_0000;
    end

    // one transfer, entered just after a rising edge
    // the request is held until pready is seen high; a stall past 16 edges is reported as hung
    task automatic xfer(input logic wr, input logic [15:0] addr, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err, output logic hung);
        int n;
        hung    = 1'b1;
        rd      = 32'h0000_0000;
        err     = 1'b0;
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) begin
                rd   = prdata;
                err  = pslverr;
                hung = 1'b0;
                break;
            end
        end
        // release after the answering edge, then one idle edge so psel never toggles twice at once
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// File: verification/controller_status_words_test.sv
// self-checking bench for the read-only status word bank
`timescale 1ns/1ps
`default_nettype none

module controller_status_words_test
    import csw_pkg::*;
;
    localparam int NLIM = 9;

    logic                           pclk;
    logic                           presetn;
    logic                           psel;
    logic                           penable;
    logic                           pwrite;
    logic [15:0]                    paddr;
    logic [31:0]                    pwdata;
    logic [31:0]                    prdata;
    logic                           pready;
    logic                           pslverr;
    csw_state_in_t [CH_COUNT-1:0]   chan_state;
    csw_alarm_in_t [CH_COUNT-1:0]   chan_alarm;
    csw_limits_t   [CH_COUNT-1:0]   chan_limits;
    logic                           ram_only_write_mode;
    logic                           nvm_differs;
    int                             n_fail;
    int                             compares;
    int                             c;
    int                             k;
    logic [31:0]                    rd;
    logic                           err;
    logic [15:0]                    a;

    // word bit of each struct field, msb field first
    int          spos [8] = '{0, 1, 2, 3, 4, 5, 8, 9};
    int          apos [7] = '{2, 1, 0, 4, 5, 6, 7};
    logic [31:0] uexp [3] = '{32'h0000_033F, 32'h0000_F0F7, 32'h0230_0000};
    // limit cases: setpoint, sp upper/lower, output upper/lower, scaling upper/lower (signed)
    csw_limits_t lim_tab [NLIM] = '{
        '{16'h0000, 16'h0064, 16'hFF9C, 16'h0064, 16'h0000, 16'h0064, 16'hFF9C},
        '{16'h0065, 16'h0064, 16'hFF9C, 16'h0064, 16'h0000, 16'h0064, 16'hFF9C},
        '{16'h0064, 16'h0064, 16'hFF9C, 16'h0064, 16'h0000, 16'h0064, 16'hFF9C},
        '{16'hFF9B, 16'h0064, 16'hFF9C, 16'h0064, 16'h0000, 16'h0064, 16'hFF9C},
        '{16'h0000, 16'hFF9B, 16'hFF9C, 16'h0064, 16'h0000, 16'h0064, 16'hFF9C},
        '{16'h0000, 16'h0000, 16'h0000, 16'h0064, 16'h0000, 16'h0064, 16'hFF9C},
        '{16'h0000, 16'h0064, 16'hFF9C, 16'hFFFF, 16'h0000, 16'h0064, 16'hFF9C},
        '{16'h0000, 16'h0064, 16'hFF9C, 16'h0064, 16'h0000, 16'hFF9B, 16'hFF9C},
        '{16'h0000, 16'hFF9B, 16'hFF9C, 16'hFFFF, 16'h0000, 16'hFF9B, 16'hFF9C}};
    logic [15:0] lim_exp [NLIM] = '{16'h0000, 16'h1000, 16'h0000, 16'h1000, 16'h3000,
                                    16'h0000, 16'h4000, 16'h8000, 16'hF000};

    csw_host_model u_csw_host_model (
        .pclk    (pclk),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr)
    );

    csw_regs u_csw_regs (
        .pclk                (pclk),
        .presetn             (presetn),
        .psel                (psel),
        .penable             (penable),
        .pwrite              (pwrite),
        .paddr               (paddr),
        .pwdata              (pwdata),
        .prdata              (prdata),
        .pready              (pready),
        .pslverr             (pslverr),
        .chan_state          (chan_state),
        .chan_alarm          (chan_alarm),
        .chan_limits         (chan_limits),
        .ram_only_write_mode (ram_only_write_mode),
        .nvm_differs         (nvm_differs)
    );

    // 20 mhz clock
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("compares %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // one bus transfer with all-ones write data; a hung slave ends the run
    task automatic xfer(input logic wr, input logic [15:0] addr, output logic [31:0] d, output logic e);
        logic hung;
        u_csw_host_model.xfer(wr, addr, 32'hFFFF_FFFF, d, e, hung);
        if (hung) begin
            n_fail++;
            end_of_test();
        end
    endtask

    // read a word and check both data and error response
    task automatic rchk(input logic [15:0] addr, input logic [31:0] exp, input logic experr);
        logic [31:0] d;
        logic        e;
        xfer(1'b0, addr, d, e);
        chk(d, exp);
        chk({31'h0000_0000, e}, {31'h0000_0000, experr});
    endtask

    // byte address of a channel's status word; alarm word is the next one
    function automatic logic [15:0] st_addr(input int ch);
        return (16'h0101 + 16'(ch) * 16'h0100) << 2;
    endfunction

    // main sequence; inputs change at an edge and one edge passes before a read
    initial begin
        n_fail = 0;
        compares = 0;
        presetn = 1'b0;
        ram_only_write_mode = 1'b0;
        nvm_differs = 1'b0;
        chan_state = '0;
        chan_alarm = '0;
        for (c = 0; c < CH_COUNT; c++) begin
            chan_limits[c] = lim_tab[0];
        end
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk(16'h0004, 32'h0200_0000, 1'b0);
        // write mode and memory match, all four combinations
        for (k = 0; k < 4; k++) begin
            ram_only_write_mode <= k[0];
            nvm_differs <= k[1];
            @(posedge pclk);
            rchk(16'h0004, 32'h0200_0000 | (32'(k[0]) << 20) | (32'(k[1]) << 21), 1'b0);
        end
        // walking one through each channel's state and alarm inputs; the next channel's status word, then the own status word, must stay clear
        for (c = 0; c < CH_COUNT; c++) begin
            for (k = 0; k < 8; k++) begin
                chan_state[c] <= csw_state_in_t'(8'h80 >> k);
                @(posedge pclk);
                rchk(st_addr(c), 32'h0000_0001 << spos[k], 1'b0);
                rchk(st_addr((c + 1) % 4), 32'h0000_0000, 1'b0);
            end
            chan_state[c] <= '0;
            for (k = 0; k < 7; k++) begin
                chan_alarm[c] <= csw_alarm_in_t'(7'h40 >> k);
                @(posedge pclk);
                rchk(st_addr(c) + 16'h0004, 32'h0000_0001 << apos[k], 1'b0);
                rchk(st_addr(c), 32'h0000_0000, 1'b0);
            end
            chan_alarm[c] <= '0;
        end
        // everything set: unused bits stay zero and writes change nothing
        chan_state[2] <= '1;
        chan_alarm[2] <= '1;
        chan_limits[2] <= lim_tab[NLIM-1];
        @(posedge pclk);
        for (k = 0; k < 3; k++) begin
            a = (k == 2) ? 16'h0004 : st_addr(2) + 16'(4 * k);
            xfer(1'b1, a, rd, err);
            chk({31'h0000_0000, err}, 32'h0000_0000);
            rchk(a, uexp[k], 1'b0);
        end
        chan_state[2] <= '0;
        chan_alarm[2] <= '0;
        nvm_differs <= 1'b0;
        // signed limit comparisons, boundaries and equal limits, rotated over channels
        for (k = 0; k < NLIM; k++) begin
            c = k % 4;
            chan_limits[c] <= lim_tab[k];
            @(posedge pclk);
            rchk(st_addr(c) + 16'h0004, {16'h0000, lim_exp[k]}, 1'b0);
            chan_limits[c] <= lim_tab[0];
        end
        rchk(16'h0004, 32'h0210_0000, 1'b0);
        // unmapped and misaligned addresses are refused
        rchk(16'h0000, 32'h0000_0000, 1'b1);
        rchk(16'h0405, 32'h0000_0000, 1'b1);
        rchk(16'h040C, 32'h0000_0000, 1'b1);
        rchk(16'h1404, 32'h0000_0000, 1'b1);
        end_of_test();
    end
endmodule
`default_nettype wire
